// ### hw/adcsc_cmp_unit.sv
// One result compare unit: match counter and match pulse.
// Assumes result strobe and data come from logic on hclk.
module adcsc_cmp_unit
    import adcsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic compare_enable,
    input wire logic compare_condition,
    input wire logic [2:0] compare_channel_select,
    input wire logic [9:0] compare_threshold,
    input wire logic [3:0] match_count_limit,
    input wire logic restart,
    input wire logic result_load,
    input wire logic [2:0] result_channel,
    input wire logic [9:0] result_data,
    output logic match_pulse
);

    function automatic logic cond_met(input logic c, input logic [9:0] r, input logic [9:0] t);
        return c ? (r >= t) : (r < t);
    endfunction

    adcsc_cmp_state_t st_q;
    adcsc_cmp_state_t st_d;
    logic qual;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.hit = 1'b0;
        qual = result_load && compare_enable && (result_channel == compare_channel_select); // RULE_08
        // A new setting starts the count afresh
        if (restart || !compare_enable) begin
            st_d.cnt = ADCSC_CNT_RST;
        end else if (qual) begin
            if (cond_met(compare_condition, result_data, compare_threshold)) begin // RULE_09
                if (st_q.cnt == match_count_limit) begin // RULE_10
                    st_d.hit = 1'b1;
                    st_d.cnt = ADCSC_CNT_RST;
                end else begin
                    st_d.cnt = st_q.cnt + 4'h1;
                end
            end else begin
                // Matches must be consecutive
                st_d.cnt = ADCSC_CNT_RST;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign match_pulse = st_q.hit;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence qual_event;
        result_load && compare_enable && !restart && (result_channel == compare_channel_select);
    endsequence

    sequence cond_hit;
        qual_event ##0 cond_met(compare_condition, result_data, compare_threshold);
    endsequence

    hit_cause_a: assert property (st_q.hit |-> $past(qual && !restart && compare_enable)) // RULE_08
        else $error("Match pulse without a qualifying result");
    hit_count_a: assert property (cond_hit ##0 (st_q.cnt == match_count_limit) |=> st_q.hit) // RULE_10
        else $error("Match count reached but no match pulse");
    miss_clear_a: assert property (qual_event ##0 !cond_met(compare_condition, result_data, compare_threshold)
        |=> (st_q.cnt == ADCSC_CNT_RST) && !st_q.hit) // RULE_09
        else $error("Failed condition did not clear counter");
    cnt_step_a: assert property (cond_hit ##0 (st_q.cnt != match_count_limit) |=> st_q.cnt == $past(st_q.cnt) + 4'h1) // RULE_09
        else $error("Counter did not step on match");

endmodule

// ### hw/adcsc_pkg.sv
// Package for the converter channel select and result compare block.
// Assumes an AHB-Lite master with word accesses and one clock domain.
package adcsc_pkg;

    localparam int unsigned ADCSC_AW = 12;
    localparam int unsigned ADCSC_NCMP = 2;

    // Register byte offsets
    localparam logic [11:0] ADCSC_OFF_CHEN = 12'h024;
    localparam logic [11:0] ADCSC_OFF_CMP0 = 12'h028;
    localparam logic [11:0] ADCSC_OFF_CMP1 = 12'h02C;
    localparam logic [11:0] ADCSC_OFF_STAT = 12'h040;
    localparam logic [11:0] ADCSC_OFF_MASK = 12'h044;

    // Reset values and writable bit masks
    localparam logic [31:0] ADCSC_RST_VAL = 32'h0000_0000;
    localparam logic [31:0] ADCSC_CHEN_MASK = 32'h0000_01FF;
    localparam logic [31:0] ADCSC_CMP_MASK = 32'h03FF_0F3F;
    localparam logic [3:0] ADCSC_CNT_RST = 4'h0;

    // Field positions
    localparam int unsigned ADCSC_SRC_BIT = 8;
    localparam int unsigned ADCSC_THR_LSB = 16;
    localparam int unsigned ADCSC_CNT_LSB = 8;
    localparam int unsigned ADCSC_CH_LSB = 3;
    localparam int unsigned ADCSC_COND_BIT = 2;
    localparam int unsigned ADCSC_IE_BIT = 1;
    localparam int unsigned ADCSC_EN_BIT = 0;

    typedef enum logic [5:0] {
        ADCSC_REG_NONE = 6'b00_0001,
        ADCSC_REG_CHEN = 6'b00_0010,
        ADCSC_REG_CMP0 = 6'b00_0100,
        ADCSC_REG_CMP1 = 6'b00_1000,
        ADCSC_REG_STAT = 6'b01_0000,
        ADCSC_REG_MASK = 6'b10_0000
    } adcsc_reg_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic hit;
    } adcsc_cmp_state_t;

    typedef struct packed {
        logic [8:0] chen;
        logic [1:0][31:0] cmp;
        logic [1:0] status;
        logic [1:0] mask;
        logic dp_valid;
        logic dp_write;
        adcsc_reg_t dp_reg;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic irq;
        logic cmp_irq;
        logic [2:0] sel_ch;
        logic sel_valid;
        logic ch7_bg;
    } adcsc_top_state_t;

endpackage

// ### hw/adcsc_top.sv
// Channel enable and result compare registers of the converter control block.
// Assumes one AHB-Lite master, hready fed back from hreadyout, and converter
// result strobe, channel and data produced on hclk.
//
// Behaviour
// RULE_01: A 32-bit channel enable register sits at 0x24, resets to zero and is read and write.
// RULE_02: Bits 7 to 0 enable input channels 7 to 0, one meaning enabled.
// RULE_03: Bit 8 picks the channel 7 source, zero external input and one the bandgap reference.
// RULE_04: Software keeps the converter clock below 300 kHz while the bandgap reference feeds channel 7.
// RULE_05: With several channels enabled only the lowest numbered one is converted.
// RULE_06: Two identical 32-bit compare registers sit at 0x28 and 0x2C, reset to zero, read and write.
// RULE_07: Threshold is bits 25 to 16, match count 11 to 8, channel 5 to 3, condition, irq enable, enable 2 to 0.
// RULE_08: When enabled each result load of the selected channel is compared with the threshold.
// RULE_09: Condition zero counts results below the threshold, condition one results at or above it.
// RULE_10: The compare flag is set when the match counter reaches the match count plus one.
// RULE_11: A set compare flag with its irq enable raises a compare interrupt request.
// RULE_12: Reserved bits read zero and ignore writes.
//
// Chosen here: the AHB-Lite slave port.
module adcsc_top
    import adcsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic result_load,
    input wire logic [2:0] result_channel,
    input wire logic [9:0] result_data,
    output logic [2:0] conv_channel,
    output logic conv_channel_valid,
    output logic ch7_source_select,
    output logic compare_irq,
    output logic irq
);

    function automatic adcsc_reg_t decode(input logic [ADCSC_AW-1:0] a);
        unique case (a)
            ADCSC_OFF_CHEN: return ADCSC_REG_CHEN;
            ADCSC_OFF_CMP0: return ADCSC_REG_CMP0;
            ADCSC_OFF_CMP1: return ADCSC_REG_CMP1;
            ADCSC_OFF_STAT: return ADCSC_REG_STAT;
            ADCSC_OFF_MASK: return ADCSC_REG_MASK;
            default: return ADCSC_REG_NONE;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input adcsc_reg_t r, input adcsc_top_state_t s);
        unique case (r)
            ADCSC_REG_CHEN: return {23'h00_0000, s.chen};
            ADCSC_REG_CMP0: return s.cmp[0];
            ADCSC_REG_CMP1: return s.cmp[1];
            ADCSC_REG_STAT: return {30'h0000_0000, s.status};
            ADCSC_REG_MASK: return {30'h0000_0000, s.mask};
            default: return ADCSC_RST_VAL;
        endcase
    endfunction

    adcsc_top_state_t st_q;
    adcsc_top_state_t n;
    logic [1:0] hit;
    logic [1:0] wr_cmp;
    logic [1:0] clr;
    logic [1:0] ie;
    logic addr_take;
    logic dp_wr;

    assign addr_take = hsel && hready && htrans[1];
    assign dp_wr = st_q.dp_valid && st_q.dp_write;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare units
    generate
        for (genvar g = 0; g < ADCSC_NCMP; g++) begin : gen_cmp
            assign ie[g] = st_q.cmp[g][ADCSC_IE_BIT];
            adcsc_cmp_unit u_cmp (
                .hclk(hclk),
                .hresetn(hresetn),
                .compare_enable(st_q.cmp[g][ADCSC_EN_BIT]), // RULE_07
                .compare_condition(st_q.cmp[g][ADCSC_COND_BIT]), // RULE_07
                .compare_channel_select(st_q.cmp[g][ADCSC_CH_LSB +: 3]), // RULE_07
                .compare_threshold(st_q.cmp[g][ADCSC_THR_LSB +: 10]), // RULE_07
                .match_count_limit(st_q.cmp[g][ADCSC_CNT_LSB +: 4]), // RULE_07
                .restart(wr_cmp[g]),
                .result_load(result_load),
                .result_channel(result_channel),
                .result_data(result_data),
                .match_pulse(hit[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n = st_q;
        wr_cmp = 2'b00;
        clr = 2'b00;
        // Data phase write, one cycle after the address phase
        if (dp_wr) begin
            unique case (st_q.dp_reg)
                ADCSC_REG_CHEN: n.chen = hwdata[8:0]; // RULE_01 RULE_12
                ADCSC_REG_CMP0: begin
                    n.cmp[0] = hwdata & ADCSC_CMP_MASK; // RULE_06 RULE_12
                    wr_cmp[0] = 1'b1;
                end
                ADCSC_REG_CMP1: begin
                    n.cmp[1] = hwdata & ADCSC_CMP_MASK; // RULE_06 RULE_12
                    wr_cmp[1] = 1'b1;
                end
                ADCSC_REG_STAT: clr = hwdata[1:0];
                ADCSC_REG_MASK: n.mask = hwdata[1:0];
                ADCSC_REG_NONE: ;
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        n.status = (st_q.status & ~clr) | hit; // RULE_10
        n.dp_valid = addr_take;
        n.dp_write = hwrite;
        n.dp_reg = decode(haddr[ADCSC_AW-1:0]);
        // Read data built from next state so a write just before is seen
        if (addr_take && !hwrite) begin
            n.rdata = read_word(n.dp_reg, n);
        end
        n.ready = 1'b1;
        n.resp = 1'b0;
        // Lowest enabled channel wins: scan downward, last hit stays
        n.sel_valid = 1'b0;
        n.sel_ch = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (st_q.chen[i]) begin // RULE_02 RULE_05
                n.sel_valid = 1'b1;
                n.sel_ch = 3'(i);
            end
        end
        // Bandgap selection needs a slow converter clock, set by software
        n.ch7_bg = st_q.chen[ADCSC_SRC_BIT]; // RULE_03 RULE_04
        n.cmp_irq = |(st_q.status & ie); // RULE_11
        n.irq = |(st_q.status & ie & st_q.mask); // RULE_11
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.dp_reg <= ADCSC_REG_NONE;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= n;
        end
    end

    assign hreadyout = st_q.ready;
    assign hrdata = st_q.rdata;
    assign hresp = st_q.resp;
    assign conv_channel = st_q.sel_ch;
    assign conv_channel_valid = st_q.sel_valid;
    assign ch7_source_select = st_q.ch7_bg;
    assign compare_irq = st_q.cmp_irq;
    assign irq = st_q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence chen_write;
        dp_wr && (st_q.dp_reg == ADCSC_REG_CHEN);
    endsequence

    sequence chen_read_back;
        addr_take && !hwrite && (decode(haddr[ADCSC_AW-1:0]) == ADCSC_REG_CHEN) && !dp_wr;
    endsequence

    chen_write_a: assert property (chen_write |=> st_q.chen == $past(hwdata[8:0])) // RULE_01
        else $error("Channel enable write not stored");
    chen_read_a: assert property (chen_read_back |=> hrdata == {23'h00_0000, $past(st_q.chen)}) // RULE_01
        else $error("Channel enable read back wrong");
    sel_valid_a: assert property (1'b1 |=> conv_channel_valid == (|$past(st_q.chen[7:0]))) // RULE_02
        else $error("Channel valid not tied to enables");
    sel_lowest_a: assert property (conv_channel_valid |-> ($past(st_q.chen[7:0])
        & ((8'h01 << conv_channel) | ((8'h01 << conv_channel) - 8'h01))) == (8'h01 << conv_channel)) // RULE_05
        else $error("Selected channel is not the lowest enabled");
    ch7_src_a: assert property (1'b1 |=> ch7_source_select == $past(st_q.chen[ADCSC_SRC_BIT])) // RULE_03
        else $error("Channel 7 source not following bit 8");
    cmp_write_a: assert property (dp_wr && (st_q.dp_reg == ADCSC_REG_CMP1)
        |=> st_q.cmp[1] == ($past(hwdata) & ADCSC_CMP_MASK)) // RULE_06
        else $error("Compare register write not masked and stored");
    reserved_zero_a: assert property ((st_q.cmp[0] & ~ADCSC_CMP_MASK) == ADCSC_RST_VAL) // RULE_12
        else $error("Reserved compare bits not zero");
    flag_set_a: assert property (hit[0] |=> st_q.status[0] ##1 1'b1) // RULE_10
        else $error("Match pulse did not set flag");
    cmp_irq_a: assert property (st_q.status[1] && ie[1] |=> compare_irq) // RULE_11
        else $error("Flag with irq enable did not raise request");
    irq_mask_a: assert property (irq |-> $past(|(st_q.status & ie & st_q.mask))) // RULE_11
        else $error("Interrupt without unmasked flag");

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage and read path

    sequence cmp0_write;
        dp_wr && (st_q.dp_reg == ADCSC_REG_CMP0);
    endsequence

    sequence cmp0_read_back;
        addr_take && !hwrite && (decode(haddr[ADCSC_AW-1:0]) == ADCSC_REG_CMP0) && !dp_wr;
    endsequence

    sequence cmp1_read_back;
        addr_take && !hwrite && (decode(haddr[ADCSC_AW-1:0]) == ADCSC_REG_CMP1) && !dp_wr;
    endsequence

    // Unmapped offsets must not leak a stale word onto the bus
    sequence hole_read;
        addr_take && !hwrite && (decode(haddr[ADCSC_AW-1:0]) == ADCSC_REG_NONE);
    endsequence

    cmp0_write_a: assert property (cmp0_write |=> st_q.cmp[0] == ($past(hwdata) & ADCSC_CMP_MASK)) // RULE_06
        else $error("Compare register 0 write not masked and stored");
    chen_hold_a: assert property (!(dp_wr && (st_q.dp_reg == ADCSC_REG_CHEN)) |=> $stable(st_q.chen)) // RULE_01
        else $error("Channel enable changed without a write");
    cmp0_hold_a: assert property (!(dp_wr && (st_q.dp_reg == ADCSC_REG_CMP0)) |=> $stable(st_q.cmp[0])) // RULE_06
        else $error("Compare register 0 changed without a write");
    cmp1_hold_a: assert property (!(dp_wr && (st_q.dp_reg == ADCSC_REG_CMP1)) |=> $stable(st_q.cmp[1])) // RULE_06
        else $error("Compare register 1 changed without a write");
    cmp0_read_a: assert property (cmp0_read_back |=> hrdata == $past(st_q.cmp[0])) // RULE_06
        else $error("Compare register 0 read back wrong");
    cmp1_read_a: assert property (cmp1_read_back |=> hrdata == $past(st_q.cmp[1])) // RULE_06
        else $error("Compare register 1 read back wrong");
    hole_read_a: assert property (hole_read |=> hrdata == ADCSC_RST_VAL) // RULE_12
        else $error("Unmapped offset did not read zero");
    chen_rsvd_a: assert property (chen_read_back |=> hrdata[31:9] == 23'h00_0000) // RULE_12
        else $error("Reserved channel enable bits not zero");
    reserved_one_a: assert property ((st_q.cmp[1] & ~ADCSC_CMP_MASK) == ADCSC_RST_VAL) // RULE_12
        else $error("Reserved compare 1 bits not zero");
    bus_okay_a: assert property (hreadyout && !hresp) // RULE_01
        else $error("Bus answer not ready and okay");

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky flags: set by a match pulse, cleared only by a written one

    sequence stat_clear0;
        dp_wr && (st_q.dp_reg == ADCSC_REG_STAT) && hwdata[0];
    endsequence

    sequence stat_clear1;
        dp_wr && (st_q.dp_reg == ADCSC_REG_STAT) && hwdata[1];
    endsequence

    flag_set1_a: assert property (hit[1] |=> st_q.status[1]) // RULE_10
        else $error("Match pulse did not set flag 1");
    flag_clear0_a: assert property (stat_clear0 ##0 !hit[0] |=> !st_q.status[0]) // RULE_10
        else $error("Written one did not clear flag 0");
    flag_clear1_a: assert property (stat_clear1 ##0 !hit[1] |=> !st_q.status[1]) // RULE_10
        else $error("Written one did not clear flag 1");
    flag_keep0_a: assert property (st_q.status[0] && !(dp_wr && (st_q.dp_reg == ADCSC_REG_STAT) && hwdata[0])
        |=> st_q.status[0]) // RULE_10
        else $error("Flag 0 dropped without a clear");
    flag_keep1_a: assert property (st_q.status[1] && !(dp_wr && (st_q.dp_reg == ADCSC_REG_STAT) && hwdata[1])
        |=> st_q.status[1]) // RULE_10
        else $error("Flag 1 dropped without a clear");
    flag_rise0_a: assert property ($rose(st_q.status[0]) |-> $past(hit[0])) // RULE_10
        else $error("Flag 0 rose without a match pulse");
    flag_rise1_a: assert property ($rose(st_q.status[1]) |-> $past(hit[1])) // RULE_10
        else $error("Flag 1 rose without a match pulse");

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt outputs and channel select timing

    cmp_irq0_a: assert property (st_q.status[0] && ie[0] |=> compare_irq) // RULE_11
        else $error("Flag 0 with irq enable did not raise request");
    cmp_irq_cause_a: assert property (compare_irq |-> $past(|(st_q.status & ie))) // RULE_11
        else $error("Compare request without an enabled flag");
    irq_raise_a: assert property (|(st_q.status & ie & st_q.mask) |=> irq) // RULE_11
        else $error("Unmasked flag did not raise interrupt");
    // The mask only narrows the request, never widens it
    irq_sub_a: assert property (irq |-> compare_irq) // RULE_11
        else $error("Interrupt without compare request");
    // Selection lags the register by one edge, two after the data phase
    sel_follow_a: assert property ($changed(conv_channel_valid) |-> $past(dp_wr && (st_q.dp_reg == ADCSC_REG_CHEN), 2)) // RULE_02
        else $error("Channel valid changed without an enable write");

endmodule

// ### test/adcsc_top_tb_top.sv
// Self-checking bench for the channel select and result compare registers.
// Assumes hready is fed back from hreadyout and the bench plays the converter strobe.
module adcsc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic result_load = 1'b0;
    logic [2:0] result_channel = 3'h0;
    logic [9:0] result_data = 10'h000;
    logic hreadyout, hresp, conv_channel_valid, ch7_source_select, compare_irq, irq;
    logic [31:0] hrdata;
    logic [2:0] conv_channel;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 34272;
    logic [31:0] m_chen = 32'h0000_0000;
    logic [31:0] m_stat = 32'h0000_0000;
    logic [31:0] m_mask = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] m_cmp [2] = '{32'h0000_0000, 32'h0000_0000};
    int cnt [2] = '{0, 0};

    adcsc_top adcsc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .result_load(result_load), .result_channel(result_channel),
        .result_data(result_data), .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid),
        .ch7_source_select(ch7_source_select), .compare_irq(compare_irq), .irq(irq));

    always #2.5 hclk = ~hclk;

    // Hang guard, generous against the roughly 1100 cycles the run needs
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Single word transfer; read data is taken at the edge ending the data phase
    task automatic ahb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr_en;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        chk("hresp", 32'h0000_0000, hresp);
        chk("hreadyout", 32'h0000_0001, hreadyout);
    endtask

    function automatic logic [31:0] mdl(input logic [11:0] a);
        case (a)
            ADCSC_OFF_CHEN: return m_chen;
            ADCSC_OFF_CMP0: return m_cmp[0];
            ADCSC_OFF_CMP1: return m_cmp[1];
            ADCSC_OFF_STAT: return m_stat;
            ADCSC_OFF_MASK: return m_mask;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        case (a)
            ADCSC_OFF_CHEN: m_chen = d & 32'h0000_01FF;
            ADCSC_OFF_CMP0, ADCSC_OFF_CMP1: begin
                m_cmp[a[2]] = d & 32'h03FF_0F3F;
                cnt[a[2]] = 0;
            end
            ADCSC_OFF_STAT: m_stat = m_stat & ~(d & 32'h0000_0003);
            ADCSC_OFF_MASK: m_mask = d & 32'h0000_0003;
            default: ;
        endcase
    endtask

    task automatic rdchk(input logic [11:0] a);
        ahb(1'b0, a, 32'h0000_0000);
        chk($sformatf("read %h", a), mdl(a), rd);
    endtask

    // One result strobe; the model counts consecutive qualifying matches
    task automatic res(input logic [2:0] ch, input logic [9:0] d);
        logic [31:0] c;
        logic m;
        @(posedge hclk);
        result_load <= 1'b1;
        result_channel <= ch;
        result_data <= d;
        @(posedge hclk);
        result_load <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            c = m_cmp[i];
            m = c[2] ? (d >= c[25:16]) : (d < c[25:16]);
            if (c[0] && ch == c[5:3]) begin
                cnt[i] = m ? cnt[i] + 1 : 0;
                if (cnt[i] == c[11:8] + 1) begin
                    m_stat[i] = 1'b1;
                    cnt[i] = 0;
                end
            end
        end
        repeat (4) @(posedge hclk);
        chk("compare_irq", |(m_stat[1:0] & {m_cmp[1][1], m_cmp[0][1]}), compare_irq);
        chk("irq", |(m_stat[1:0] & m_mask[1:0] & {m_cmp[1][1], m_cmp[0][1]}), irq);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        int low;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(ADCSC_OFF_CHEN);
        rdchk(ADCSC_OFF_CMP0);
        rdchk(ADCSC_OFF_CMP1);
        wr(12'h030, $random(seed));
        rdchk(12'h030);
        // Sparse random patterns make the lowest-channel pick non-trivial
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'h0000_0180 : $random(seed) & $random(seed);
            wr(ADCSC_OFF_CHEN, v);
            rdchk(ADCSC_OFF_CHEN);
            repeat (2) @(posedge hclk);
            low = 0;
            for (int i = 7; i >= 0; i--) begin
                if (m_chen[i]) low = i;
            end
            chk("conv_channel", low, conv_channel);
            chk("conv_channel_valid", |m_chen[7:0], conv_channel_valid);
            chk("ch7_source_select", m_chen[8], ch7_source_select);
        end
        // Limits kept to 0..3, strobes aimed at or next to a unit's channel so flags get set
        for (int k = 0; k < 8; k++) begin
            wr(ADCSC_OFF_CMP0, $random(seed) & 32'hFFFF_F3FF);
            rdchk(ADCSC_OFF_CMP0);
            wr(ADCSC_OFF_CMP1, $random(seed) & 32'hFFFF_F3FF);
            rdchk(ADCSC_OFF_CMP1);
            wr(ADCSC_OFF_MASK, $random(seed));
            rdchk(ADCSC_OFF_MASK);
            for (int j = 0; j < 16; j++) begin
                res(m_cmp[j % 2][5:3] ^ {2'b00, 1'($random(seed))}, 10'($random(seed)));
            end
            rdchk(ADCSC_OFF_STAT);
            wr(ADCSC_OFF_STAT, $random(seed));
            rdchk(ADCSC_OFF_STAT);
        end
        conclude();
    end
endmodule
